/* File: pkg/acws_pkg.sv */
// Package for the converter control-word decoder and channel sequencer.
package acws_pkg;
   // ==========================================================
   // Control word layout
   localparam int WORD_BITS      = 12;
   localparam int XFER_EDGES     = 16;
   localparam int MASK_BITS      = 16;
   localparam int BIT_UPDATE     = 11;
   localparam int BIT_SEQ_EN     = 10;
   localparam int BIT_CH_HI      = 9;
   localparam int BIT_CH_LO      = 6;
   localparam int BIT_PM_HI      = 5;
   localparam int BIT_PM_LO      = 4;
   localparam int BIT_SEQ_PROG   = 3;
   localparam int BIT_WEAK_OUT   = 2;
   localparam int BIT_SPAN       = 1;
   localparam int BIT_CODING     = 0;
   localparam int MUX_EDGE       = 14;
   localparam int ADDR_BITS      = 4;
   localparam int RESULT_BITS    = 12;
   // ==========================================================
   // Reset value of the configuration: normal power, ones elsewhere off.
   localparam logic [10:0] CFG_RESET = 11'h030;
   // ==========================================================
   // Timing
   localparam int CLK_MHZ        = 100;
   localparam int WAKE_NS        = 1000;
   localparam int WAKE_CYCLES    = (WAKE_NS * CLK_MHZ + 999) / 1000;
   localparam int STBY_NS        = 1000;
   localparam int STBY_CYCLES    = (STBY_NS * CLK_MHZ + 999) / 1000;

   typedef enum logic [1:0] {
      ACWS_PM_STANDBY  = 2'h0,
      ACWS_PM_AUTO_OFF = 2'h1,
      ACWS_PM_SHUTDOWN = 2'h2,
      ACWS_PM_NORMAL   = 2'h3
   } acws_pm_t;

   typedef enum logic [1:0] {
      ACWS_SQ_SINGLE   = 2'h0,
      ACWS_SQ_PROGRAM  = 2'h1,
      ACWS_SQ_KEEP     = 2'h2,
      ACWS_SQ_CONSEC   = 2'h3
   } acws_sq_t;

   typedef enum logic [2:0] {
      ACWS_MASK_RUN    = 3'h1,
      ACWS_CONSEC_RUN  = 3'h2,
      ACWS_NO_SEQ      = 3'h4
   } acws_state_t;

   typedef struct packed {
      logic           seq_en;
      logic [3:0]     channel_select;
      logic           power_mode_hi;
      logic           power_mode_lo;
      logic           seq_prog;
      logic           weak_out;
      logic           span_ref;
      logic           straight_binary;
   } acws_cfg_t;

   typedef struct packed {
      logic           powered;
      logic           bias_on;
      logic           awake;
      logic           span_ref;
      logic           straight_binary;
   } acws_analog_t;
endpackage

/* File: core/acws_sync.sv */
// Two-flop synchroniser bank for pin inputs.
`timescale 1ns/100ps
`default_nettype none
module acws_sync #(
   parameter int W = 3
) (
   input  wire logic         mclk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta;

   // ==========================================================
   // Synchroniser
   // The first stage feeds only the second, to keep metastability contained.
   // Both stages reset to ones, the idle level of the serial pins, so no false edge follows reset.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         meta <= '1;
         q    <= '1;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule
`default_nettype wire

/* File: core/acws_core.sv */
// Control-word decoder and channel sequencer for a 16-input serial converter.
// Notes on behaviour
// - Load the 11 lower bits only when the update bit is one.
// - Sequencer enable and program bit together pick one of four modes.
// - Channel field bits 9..6 are an unsigned index 0 to 15.
// - A new channel field takes effect at the 14th falling edge of the frame that writes it.
// - The result's channel address leads the 12 result bits out.
// - The mux moves to the next channel on the 14th falling clock edge.
// - Power bits 5,4: 11 normal, 10 shutdown, 01 auto shutdown, 00 standby.
// - Normal mode keeps everything powered whatever the inputs do.
// - Full shutdown keeps configuration and lasts until power bits change.
// - Auto shutdown powers down after updating conversions; wake takes 1 us.
// - Auto standby keeps bias on and recovers within one dummy transfer.
// - Bit 2 set: output weakly holds next address top bit; else released.
// - Bit 1 selects span: 0 is twice reference, 1 is reference.
// - Bit 0 selects coding: 0 twos complement, 1 straight binary.
// - With both sequencer bits clear, convert the previously written channel.
// - Program mode takes the next transfer as the channel mask.
// - Mode 1,0 updates other bits without disturbing a running sequence.
// - Mode 1,1 runs channels 0 up to the selected last channel.
// - Bits enter MSB first on falling edges; first 12 of 16 are kept.
// - Mask sequence ascends from lowest until a write leaves mode 1,0.
`timescale 1ns/100ps
`default_nettype none
module acws_core
   import acws_pkg::*;
#(
   parameter int WAKE_CNT = acws_pkg::WAKE_CYCLES,
   parameter int STBY_CNT = acws_pkg::STBY_CYCLES
) (
   input  wire logic                 mclk,
   input  wire logic                 rstn,
   input  wire logic                 sclk,
   input  wire logic                 cs_n,
   input  wire logic                 din,
   input  wire logic [11:0]          result,
   output var  logic                 dout_o,
   output var  logic                 dout_oe,
   output var  logic                 dout_weak,
   output var  logic [3:0]           mux_channel,
   output var  logic                 sample,
   output var  acws_pkg::acws_cfg_t  cfg,
   output var  logic [15:0]          channel_mask,
   output var  acws_pkg::acws_analog_t analog
);
   import acws_pkg::*;

   logic [2:0]     pins;
   logic           sclk_s;
   logic           cs_n_s;
   logic           din_s;
   logic           sclk_d;
   logic           cs_d;
   logic           fall;
   logic           cs_fall;
   logic           cs_rise;
   logic [4:0]     edge_cnt;
   logic [11:0]    shift_in;
   logic [15:0]    shift_mask;
   logic [15:0]    shift_out;
   logic           in_frame;
   logic           mask_next;
   logic           mask_frame;
   logic [3:0]     conv_ch;
   logic [3:0]     next_ch;
   logic [3:0]     pend_ch;
   logic [3:0]     last_ch;
   logic           update_pend;
   logic [15:0]    wake_cnt;
   logic           asleep;
   acws_state_t    state;
   acws_pm_t       pm;
   logic [3:0]     mask_first;
   logic [3:0]     mask_after;
   logic           mask_after_ok;

   assign pins = {sclk, cs_n, din};

   acws_sync #(
      .W (3)
   ) u_sync (
      .mclk (mclk),
      .rstn (rstn),
      .d    (pins),
      .q    ({sclk_s, cs_n_s, din_s})
   );

   // ==========================================================
   // Edge detection on the synchronised serial pins
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         sclk_d <= 1'b1;
         cs_d   <= 1'b1;
      end else begin
         sclk_d <= sclk_s;
         cs_d   <= cs_n_s;
      end
   end

   assign fall    = sclk_d & ~sclk_s & ~cs_n_s;
   assign cs_fall = cs_d & ~cs_n_s;
   assign cs_rise = ~cs_d & cs_n_s;
   assign pm      = acws_pm_t'({cfg.power_mode_hi, cfg.power_mode_lo});

   // Lowest set mask bit, and lowest set bit above the channel now converted.
   always_comb begin
      mask_first    = 4'h0;
      mask_after    = 4'h0;
      mask_after_ok = 1'b0;
      for (int i = MASK_BITS - 1; i >= 0; i--) begin
         if (channel_mask[i]) begin
            mask_first = i[3:0];
         end
         if (channel_mask[i] && i > int'(conv_ch)) begin
            mask_after    = i[3:0];
            mask_after_ok = 1'b1;
         end
      end
   end

   // Channel for the next conversion, chosen by the sequencer state.
   always_comb begin
      case (state)
         ACWS_MASK_RUN: begin
            next_ch = mask_after_ok ? mask_after : mask_first;
         end
         ACWS_CONSEC_RUN: begin
            next_ch = (conv_ch >= last_ch) ? 4'h0 : conv_ch + 4'h1;
         end
         ACWS_NO_SEQ: begin
            next_ch = pend_ch;
         end
         default: begin
            next_ch = pend_ch;
         end
      endcase
   end

   // ==========================================================
   // Frame counter and input shifting
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         edge_cnt   <= 5'h00;
         in_frame   <= 1'b0;
         shift_in   <= 12'h000;
         shift_mask <= 16'h0000;
      end else if (cs_fall) begin
         edge_cnt <= 5'h00;
         in_frame <= 1'b1;
      end else if (cs_rise) begin
         in_frame <= 1'b0;
      end else if (fall && in_frame && edge_cnt < 5'(XFER_EDGES)) begin
         edge_cnt   <= edge_cnt + 5'h01;
         shift_mask <= {shift_mask[14:0], din_s};
         if (edge_cnt < 5'(WORD_BITS)) begin
            shift_in <= {shift_in[10:0], din_s};
         end
      end
   end

   // ==========================================================
   // Configuration register and mask register
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         cfg          <= acws_cfg_t'(CFG_RESET);
         channel_mask <= 16'h0000;
         mask_next    <= 1'b0;
         mask_frame   <= 1'b0;
         update_pend  <= 1'b0;
      end else begin
         update_pend <= 1'b0;
         if (cs_fall) begin
            mask_frame <= mask_next;
         end
         if (fall && in_frame && edge_cnt == 5'(XFER_EDGES - 1) && mask_frame) begin
            channel_mask <= {shift_mask[14:0], din_s};
            mask_next    <= 1'b0;
         end else if (fall && in_frame && edge_cnt == 5'(WORD_BITS - 1) && !mask_frame) begin
            if (shift_in[BIT_UPDATE-1]) begin
               cfg         <= acws_cfg_t'({shift_in[9:0], din_s});
               update_pend <= 1'b1;
               mask_next   <= ~shift_in[BIT_SEQ_EN-1] & shift_in[BIT_SEQ_PROG-1];
            end
         end
      end
   end

   // ==========================================================
   // Sequencer state and channel pointers
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state   <= ACWS_NO_SEQ;
         pend_ch <= 4'h0;
         last_ch <= 4'hF;
         conv_ch <= 4'h0;
         mux_channel <= 4'h0;
         sample  <= 1'b0;
      end else begin
         sample <= cs_fall;
         if (cs_fall) begin
            conv_ch <= mux_channel;
         end
         if (fall && in_frame && edge_cnt == 5'(MUX_EDGE - 1)) begin
            mux_channel <= next_ch;
         end
         if (update_pend) begin
            case (acws_sq_t'({cfg.seq_en, cfg.seq_prog}))
               ACWS_SQ_SINGLE: begin
                  state <= ACWS_NO_SEQ;
                  pend_ch <= cfg.channel_select;
               end
               ACWS_SQ_PROGRAM: begin
                  state <= ACWS_MASK_RUN;
               end
               ACWS_SQ_KEEP: begin
                  state <= state;
               end
               ACWS_SQ_CONSEC: begin
                  state   <= ACWS_CONSEC_RUN;
                  last_ch <= cfg.channel_select;
               end
               default: begin
                  state <= ACWS_NO_SEQ;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Power management
   // A single counter serves both wake-up times, since only one mode is active.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         asleep   <= 1'b0;
         wake_cnt <= 16'h0000;
      end else if (pm == ACWS_PM_NORMAL || pm == ACWS_PM_SHUTDOWN) begin
         asleep   <= 1'b0;
         wake_cnt <= 16'h0000;
      end else if (update_pend) begin
         asleep <= 1'b1;
      end else if (asleep && cs_fall) begin
         asleep   <= 1'b0;
         wake_cnt <= (pm == ACWS_PM_AUTO_OFF) ? 16'(WAKE_CNT) : 16'(STBY_CNT);
      end else if (wake_cnt != 16'h0000) begin
         wake_cnt <= wake_cnt - 16'h0001;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         analog <= '0;
      end else begin
         analog.powered         <= pm != ACWS_PM_SHUTDOWN && !asleep;
         analog.bias_on         <= pm != ACWS_PM_SHUTDOWN &&
                                   !(asleep && pm == ACWS_PM_AUTO_OFF);
         analog.awake           <= pm != ACWS_PM_SHUTDOWN && !asleep &&
                                   wake_cnt == 16'h0000;
         analog.span_ref        <= cfg.span_ref;
         analog.straight_binary <= cfg.straight_binary;
      end
   end

   // ==========================================================
   // Serial output
   // Data changes on falling edges so the host can sample it on the next one.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         shift_out <= 16'h0000;
         dout_o    <= 1'b0;
         dout_oe   <= 1'b0;
         dout_weak <= 1'b0;
      end else if (cs_fall) begin
         shift_out <= {mux_channel[2:0], result, 1'b0};
         dout_o    <= mux_channel[ADDR_BITS-1];
         dout_oe   <= 1'b1;
         dout_weak <= 1'b0;
      end else if (fall && in_frame && edge_cnt < 5'(XFER_EDGES - 1)) begin
         dout_o    <= shift_out[15];
         shift_out <= {shift_out[14:0], 1'b0};
      end else if (cs_rise || (fall && edge_cnt == 5'(XFER_EDGES - 1))) begin
         dout_o    <= mux_channel[ADDR_BITS-1];
         dout_oe   <= cfg.weak_out;
         dout_weak <= cfg.weak_out;
      end
   end
endmodule
`default_nettype wire

/* File: sim/acws_host.sv */
// Host serial master model: shifts words in and captures the result stream.
`timescale 1ns/100ps
`default_nettype none
module acws_host (
   input  wire logic mclk,
   input  wire logic dout_o,
   output var  logic sclk,
   output var  logic cs_n,
   output var  logic din
);
   // ======================================
   // Link clock of 160 ns stands high between frames.
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      din  = 1'b0;
   end
   // Data changes at the rising edge so it is settled at the falling one.
   task automatic frame(input logic [15:0] w, output logic [15:0] rd);
      @(posedge mclk);
      cs_n <= 1'b0;
      din  <= w[15];
      repeat (8) @(posedge mclk);
      for (int i = 15; i >= 0; i--) begin
         rd[i] = dout_o;
         sclk <= 1'b0;
         repeat (8) @(posedge mclk);
         sclk <= 1'b1;
         din  <= (i > 0) ? w[(i + 15) % 16] : ~w[0];
         repeat (8) @(posedge mclk);
      end
      cs_n <= 1'b1;
      repeat (12) @(posedge mclk);
   endtask
endmodule
`default_nettype wire

/* File: sim/acws_core_assertions.sv */
// Concurrent checks on the ports of the decoder and sequencer.
`timescale 1ns/100ps
`default_nettype none
module acws_core_assertions
   import acws_pkg::*;
#(
   parameter int WAKE_CNT = acws_pkg::WAKE_CYCLES,
   parameter int STBY_CNT = acws_pkg::STBY_CYCLES
) (
   input wire logic                   mclk,
   input wire logic                   rstn,
   input wire logic                   sclk,
   input wire logic                   cs_n,
   input wire logic                   din,
   input wire logic [11:0]            result,
   input wire logic                   dout_o,
   input wire logic                   dout_oe,
   input wire logic                   dout_weak,
   input wire logic [3:0]             mux_channel,
   input wire logic                   sample,
   input wire acws_pkg::acws_cfg_t    cfg,
   input wire logic [15:0]            channel_mask,
   input wire acws_pkg::acws_analog_t analog
);
   // ======================================
   // Wake bound covers either recovery path plus pin synchronisation.
   localparam int WAKE_LIM = WAKE_CNT + STBY_CNT + 8;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   sample_pulse_a: assert property (sample |=> !sample)
      else $error("sample pulse too long");
   frame_start_a: assert property ($fell(cs_n) |-> ##[2:6] sample)
      else $error("no sample after select");
   start_drive_a: assert property (sample
      |-> dout_oe && !dout_weak && dout_o == mux_channel[3]) else $error("bad first output bit");
   idle_drive_a: assert property (cs_n [*6] |-> dout_oe == cfg.weak_out)
      else $error("idle drive wrong");
   weak_level_a: assert property (dout_weak |-> dout_oe && dout_o == mux_channel[3])
      else $error("weak level wrong");
   cfg_hold_a: assert property (cs_n [*6] |=> $stable(cfg) && $stable(channel_mask))
      else $error("config moved while idle");
   mux_hold_a: assert property (cs_n [*6] |=> $stable(mux_channel))
      else $error("mux moved while idle");
   normal_power_a: assert property ((cs_n && cfg.power_mode_hi && cfg.power_mode_lo) [*8]
      |-> analog.powered && analog.bias_on && analog.awake) else $error("normal not powered");
   shutdown_off_a: assert property ((cfg.power_mode_hi && !cfg.power_mode_lo) [*3]
      |-> !analog.powered) else $error("shutdown powered");
   standby_bias_a: assert property ((!cfg.power_mode_hi && !cfg.power_mode_lo) [*3]
      |-> analog.bias_on) else $error("standby bias off");
   wake_bound_a: assert property ($fell(cs_n) && !cfg.power_mode_hi
      |-> ##[1:WAKE_LIM] analog.awake) else $error("wake too slow");
   cover property (sample && cfg.seq_en && cfg.seq_prog);
   cover property (sample && channel_mask != 16'h0000);
   cover property (dout_weak);
   cover property ($fell(analog.awake));
endmodule
bind acws_core acws_core_assertions #(.WAKE_CNT(WAKE_CNT), .STBY_CNT(STBY_CNT)) chk (
   .mclk(mclk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .din(din), .result(result),
   .dout_o(dout_o), .dout_oe(dout_oe), .dout_weak(dout_weak), .mux_channel(mux_channel),
   .sample(sample), .cfg(cfg), .channel_mask(channel_mask), .analog(analog));
`default_nettype wire

/* File: sim/adc_control_word_and_sequencer_test.sv */
// Self-checking bench for the decoder and sequencer.
`timescale 1ns/100ps
`default_nettype none
module adc_control_word_and_sequencer_test;
   import acws_pkg::*;
   logic         mclk, rstn, sclk, cs_n, din, dout_o, dout_oe, dout_weak, sample;
   logic [11:0]  result;
   logic [3:0]   mux_channel;
   logic [3:0]   addr [8];
   logic [15:0]  channel_mask, rd;
   acws_cfg_t    cfg;
   acws_analog_t analog;
   int           err_count = 0;
   int           checks = 0;
   int           cycles = 0;
   acws_core #(.WAKE_CNT(4), .STBY_CNT(4)) DUT (.mclk(mclk), .rstn(rstn), .sclk(sclk),
      .cs_n(cs_n), .din(din), .result(result), .dout_o(dout_o), .dout_oe(dout_oe),
      .dout_weak(dout_weak), .mux_channel(mux_channel), .sample(sample), .cfg(cfg),
      .channel_mask(channel_mask), .analog(analog));
   acws_host host (.mclk(mclk), .dout_o(dout_o), .sclk(sclk), .cs_n(cs_n), .din(din));
   // ======================================
   // Clock and hang guard; about forty frames need some 10300 cycles.
   initial mclk = 1'b0;
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         err_count++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Next member of a sequence: smallest set bit above p, else the lowest.
   function automatic logic [3:0] nxt(input logic [15:0] m, input logic [3:0] p);
      nxt = 4'h0;
      for (int i = 15; i >= 0; i--) if (m[i]) nxt = 4'(i);
      for (int i = 15; i > p; i--) if (m[i]) nxt = 4'(i);
   endfunction
   // The first frames may still belong to the previous mode, so order is judged later.
   task automatic run_seq(input logic [15:0] m);
      for (int k = 0; k < 7; k++) begin
         host.frame(16'h0000, rd);
         addr[k] = rd[15:12];
         chk({4'h0, rd[11:0]}, {4'h0, result});
         if (k >= 3) chk({12'h000, addr[k]}, {12'h000, nxt(m, addr[k-1])});
      end
   endtask
   // ======================================
   // Main sequence.
   initial begin
      rstn = 1'b0;
      result = 12'hA5C;
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      repeat (4) @(posedge mclk);
      chk({5'h00, cfg}, {5'h00, CFG_RESET});
      chk(channel_mask, 16'h0000);
      chk({15'h0000, dout_oe}, 16'h0000);
      host.frame(16'hB770, rd);
      host.frame(16'hB770, rd);
      chk({5'h00, cfg}, 16'h0377);
      chk({12'h000, mux_channel}, 16'h000D);
      chk({14'h0000, analog.span_ref, analog.straight_binary}, 16'h0003);
      chk({13'h0000, dout_oe, dout_weak, dout_o}, 16'h0007);
      host.frame(16'hB770, rd);
      chk(rd, 16'hDA5C);
      host.frame(16'h0770, rd);
      chk({5'h00, cfg}, 16'h0377);
      host.frame(16'hCB80, rd);
      run_seq(16'h0007);
      host.frame(16'hCB40, rd);
      chk({15'h0000, dout_oe}, 16'h0001);
      run_seq(16'h0007);
      host.frame(16'h8380, rd);
      host.frame(16'h8421, rd);
      chk(channel_mask, 16'h8421);
      run_seq(16'h8421);
      host.frame(16'h8F00, rd);
      host.frame(16'h8F00, rd);
      chk({12'h000, mux_channel}, 16'h0003);
      host.frame(16'h8200, rd);
      chk({14'h0000, analog.powered, analog.bias_on}, 16'h0000);
      host.frame(16'h0000, rd);
      chk({5'h00, cfg}, 16'h0020);
      chk({15'h0000, analog.powered}, 16'h0000);
      host.frame(16'h8D00, rd);
      chk({14'h0000, analog.bias_on, analog.awake}, 16'h0000);
      // Dummy transfer gives the converter its wake time before a result counts.
      host.frame(16'h0000, rd);
      chk({15'h0000, analog.awake}, 16'h0001);
      host.frame(16'h8C00, rd);
      chk({14'h0000, analog.powered, analog.bias_on}, 16'h0001);
      host.frame(16'h8F00, rd);
      chk({15'h0000, analog.powered}, 16'h0001);
      test_done();
   end
endmodule
`default_nettype wire
